// ===== rtl/cfg_loader_cfg.svh
`ifndef CFG_LOADER_CFG_SVH
`define CFG_LOADER_CFG_SVH
`define CTRL_OFFSET 8'h08
`define STATUS_OFFSET 8'h0C
`define BASE_OFFSET 8'h10
`define LEN_OFFSET 8'h14
`define SEL_LSB 0
`define SEL_MSB 2
`define OVR_BIT 3
`define TRIG_BIT 2
`define CTRL_RESET 8'h00
`define SEL_POS_LSB 4
`define OVR_POS 7
`define REGION_SHIFT 20
`define LEN_RESET 24'h010000
`define DCLK_HALF 4
`endif

// ===== rtl/cfg_loader_pkg.sv
package cfg_loader_pkg;
  typedef enum logic [2:0] {st_idle, st_addr, st_wait, st_shift_lo, st_shift_hi, st_done} ld_state_t;
  typedef struct packed {
    logic [23:0] addr;
    logic oe_n;
    logic ce_n;
  } flash_req_t;
  typedef struct packed {
    logic dclk;
    logic data;
    logic config_n;
  } cfg_pins_t;
  typedef struct packed {
    ld_state_t st;
    logic [2:0] sel;
    logic ovr;
    logic [2:0] active;
    logic busy;
    logic done_flag;
    logic [23:0] len;
    logic [23:0] cnt;
    logic [15:0] word;
    logic [3:0] bitn;
    logic [2:0] div;
    logic [1:0] wait_cnt;
    flash_req_t fl;
    cfg_pins_t cp;
    logic [7:0] rdata;
    logic [1:0] strap_sync;
  } ld_regs_t;
endpackage

// ===== rtl/flash_config_page_reset_loader.sv
`timescale 1ns/10ps
`include "cfg_loader_cfg.svh"
module flash_config_page_reset_loader (
  input wire logic clk_in, // 250 MHz clock
  input wire logic rst_in, // async reset, active high
  input wire logic [7:0] addr_in, // register byte address
  input wire logic [7:0] wdata_in, // register write data
  input wire logic wr_in, // write strobe
  input wire logic rd_in, // read strobe
  output logic [7:0] rdata_out, // read data, cycle after read
  input wire logic [2:0] strap_region_in, // region used when override is 1
  input wire logic [15:0] flash_data_in, // flash data bus
  output cfg_loader_pkg::flash_req_t flash_out, // flash address and controls
  output cfg_loader_pkg::cfg_pins_t cfg_out, // dclk, data, config_n to target
  output logic busy_out // loading in progress
);
  import cfg_loader_pkg::*;
  ld_regs_t r, next_r;
  logic [2:0] strap_q1;
  logic [2:0] strap_q2;
  logic [15:0] fd_q1;
  logic [15:0] fd_q2;
  logic [2:0] region;
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      strap_q1 <= 3'h0;
      strap_q2 <= 3'h0;
      fd_q1 <= 16'h0000;
      fd_q2 <= 16'h0000;
    end else begin
      strap_q1 <= strap_region_in;
      strap_q2 <= strap_q1;
      fd_q1 <= flash_data_in;
      fd_q2 <= fd_q1;
    end
  end
  // override 0 means software select governs
  assign region = r.ovr ? strap_q2 : r.sel;
  always_comb begin
    next_r = r;
    next_r.strap_sync = 2'b00;
    next_r.rdata = 8'h00;
    if (rd_in) begin
      unique case (addr_in)
        `CTRL_OFFSET: next_r.rdata = {r.ovr, r.sel, 4'h0};
        `STATUS_OFFSET: next_r.rdata = {r.active, 3'h0, r.done_flag, r.busy};
        `LEN_OFFSET: next_r.rdata = r.len[23:16];
        default: next_r.rdata = 8'h00;
      endcase
      if (addr_in == `STATUS_OFFSET) begin
        next_r.done_flag = 1'b0;
      end
    end
    if (wr_in && addr_in == `CTRL_OFFSET) begin
      next_r.sel = wdata_in[`SEL_POS_LSB+2:`SEL_POS_LSB];
      next_r.ovr = wdata_in[`OVR_POS];
    end
    if (wr_in && addr_in == `LEN_OFFSET) begin
      next_r.len = {wdata_in, 16'h0000};
    end
    unique case (r.st)
      st_idle: begin
        if (wr_in && addr_in == `CTRL_OFFSET && wdata_in[`TRIG_BIT]) begin
          next_r.active = region;
          next_r.busy = 1'b1;
          next_r.cnt = 24'h000000;
          next_r.cp.config_n = 1'b0;
          next_r.st = st_addr;
        end
      end
      st_addr: begin
        // region base is index times region size
        next_r.fl.addr = {r.active, 21'h0} + r.cnt;
        next_r.fl.ce_n = 1'b0;
        next_r.fl.oe_n = 1'b0;
        next_r.cp.config_n = 1'b1;
        // park dclk low between words so every high phase is exactly one half period
        next_r.cp.dclk = 1'b0;
        next_r.wait_cnt = 2'h3;
        next_r.st = st_wait;
      end
      st_wait: begin
        if (r.wait_cnt == 2'h0) begin
          next_r.word = fd_q2;
          next_r.bitn = 4'hF;
          next_r.div = 3'h0;
          next_r.st = st_shift_lo;
        end else begin
          next_r.wait_cnt = r.wait_cnt - 2'h1;
        end
      end
      st_shift_lo: begin
        next_r.cp.dclk = 1'b0;
        next_r.cp.data = r.word[0];
        next_r.div = r.div + 3'h1;
        if (r.div == 3'(`DCLK_HALF - 1)) begin
          next_r.div = 3'h0;
          next_r.st = st_shift_hi;
        end
      end
      st_shift_hi: begin
        next_r.cp.dclk = 1'b1;
        next_r.div = r.div + 3'h1;
        if (r.div == 3'(`DCLK_HALF - 1)) begin
          next_r.div = 3'h0;
          next_r.word = {1'b0, r.word[15:1]};
          next_r.bitn = r.bitn - 4'h1;
          if (r.bitn == 4'h0) begin
            next_r.cnt = r.cnt + 24'h000001;
            next_r.st = (r.cnt + 24'h000001 >= r.len) ? st_done : st_addr;
          end else begin
            next_r.st = st_shift_lo;
          end
        end
      end
      st_done: begin
        next_r.fl.ce_n = 1'b1;
        next_r.fl.oe_n = 1'b1;
        next_r.cp.dclk = 1'b0;
        next_r.busy = 1'b0;
        next_r.done_flag = 1'b1;
        next_r.st = st_idle;
      end
      default: next_r.st = st_idle;
    endcase
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
      r.st <= st_idle;
      r.len <= `LEN_RESET;
      r.fl.ce_n <= 1'b1;
      r.fl.oe_n <= 1'b1;
      r.cp.config_n <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
  assign rdata_out = r.rdata;
  assign flash_out = r.fl;
  assign cfg_out = r.cp;
  assign busy_out = r.busy;
endmodule

// ===== testbench/flash_mem.sv
`timescale 1ns/10ps
module flash_mem (
  input wire cfg_loader_pkg::flash_req_t req_in, // controls
  input wire logic clk_in, // clk
  output logic [15:0] data_out // data
);
  // released bus shows the inverse of the last value
  always_ff @(posedge clk_in) begin
    data_out <= (req_in.ce_n | req_in.oe_n) ? ~data_out :
      {req_in.addr[23:21], 13'h0} ^ 16'hA5C3;
  end
endmodule

// ===== testbench/loader_properties.sv
`timescale 1ns/10ps
module loader_props (
  input wire logic clk_in, // clk
  input wire logic rst_in, // rst
  input wire logic [7:0] addr_in, // addr
  input wire logic [7:0] wdata_in, // data
  input wire logic wr_in, // wr
  input wire logic rd_in, // rd
  input wire logic [7:0] rdata_out, // rdata
  input wire cfg_loader_pkg::flash_req_t flash_out, // flash
  input wire cfg_loader_pkg::cfg_pins_t cfg_out, // pins
  input wire logic busy_out // busy
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  logic [3:0] cs;
  wire wc = wr_in && addr_in == 8'h08;
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in) cs <= 4'h0;
    else if (wc) cs <= wdata_in[7:4];
  a_trig_start: assert property (
    wc && wdata_in[2] && !busy_out |=> busy_out && !cfg_out.config_n) else $error("start");
  a_trig_pulse: assert property (
    !cfg_out.config_n |=> cfg_out.config_n) else $error("pulse");
  a_region_addr: assert property (
    $rose(busy_out) && !cs[3] |=> flash_out.addr[23:21] == cs[2:0]) else $error("region");
  a_flash_idle: assert property (
    !flash_out.ce_n |-> busy_out) else $error("idle");
  a_dclk_half: assert property (
    $rose(cfg_out.dclk) |=> cfg_out.dclk [*3] ##1 !cfg_out.dclk) else $error("dclk");
  a_data_hold: assert property (
    cfg_out.dclk && $past(cfg_out.dclk) |-> $stable(cfg_out.data)) else $error("data");
  a_sel_hold: assert property (
    rd_in && addr_in == 8'h08 |=> rdata_out == {cs, 4'h0}) else $error("hold");
  a_no_restart: assert property (
    busy_out && $past(busy_out) |-> cfg_out.config_n) else $error("restart");
  cover property ($rose(busy_out));
  cover property ($rose(cfg_out.dclk));
  cover property (rd_in && addr_in == 8'h0C);
endmodule

// ===== testbench/flash_config_page_reset_loader_tb.sv
`timescale 1ns/10ps
`define CHK(n,e,g) checks_done++; if ((g)!==(e)) begin miscompares++; $display("CHECK FAILED %s %h %h",n,e,g); end
module flash_config_page_reset_loader_tb;
  import cfg_loader_pkg::*;
  logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, busy_out;
  logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
  logic [2:0] strap_region_in = 3'h3;
  logic [15:0] flash_data_in, w;
  flash_req_t flash_out;
  cfg_pins_t cfg_out;
  int miscompares = 0, checks_done = 0, cyc = 0;
  logic [7:0] ctl [3] = '{8'h70, 8'h90, 8'h00};
  logic [2:0] rg [3] = '{3'h7, 3'h3, 3'h0};
  flash_config_page_reset_loader u_dut (
    .clk_in(clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
    .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
    .strap_region_in(strap_region_in), .flash_data_in(flash_data_in),
    .flash_out(flash_out), .cfg_out(cfg_out), .busy_out(busy_out));
  flash_mem u_fl (.req_in(flash_out), .clk_in(clk_in), .data_out(flash_data_in));
  initial forever #2 clk_in = ~clk_in;
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task wr(input logic [7:0] a, d);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1;
    @(posedge clk_in);
    wr_in <= 0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1;
    @(posedge clk_in);
    rd_in <= 0;
    #1 `CHK("rdata", e, rdata_out)
  endtask
  initial begin
    for (int i = 0; i < 3; i++) begin
      rst_in <= 1;
      repeat (12) @(posedge clk_in);
      rst_in <= 0;
      rd(8'h08, 8'h00);
      rd(8'h20, 8'h00);
      wr(8'h08, ctl[i]);
      wr(8'h08, ctl[i] | 8'h04);
      rd(8'h08, ctl[i]);
      // first word arrives lsb first, one bit per rising dclk
      for (int b = 0; b < 16; b++) begin
        @(posedge cfg_out.dclk);
        w[b] = cfg_out.data;
      end
      `CHK("word", {rg[i], 13'h0} ^ 16'hA5C3, w)
      rd(8'h0C, {rg[i], 5'h01});
      `CHK("busy", 1'b1, busy_out)
      $display("test %0d done", i);
    end
    end_sim();
  end
endmodule
bind flash_config_page_reset_loader loader_props u_chk (.*);
